// ### inc/msi_regs.svh
// constants of the motor switch interlock controller
// Function
// [R1] host traffic: both leds flash fast together
// [R2] emergency low: switch off, leds together, refuse
// [R3] emergency high: allow switching, leds alternate
// [R4] link 19200 or 38400 baud, 8N1
// [R5] dip 1-2 protocol, dip 3 baud rate
// [R6] eight dip switches give address, baud, protocol
// [R7] every register is one 16-bit word
// [R8] state register: 0 off, 1 on
// [R9] inputs register: padlock, handle, emergency bits
// [R10] padlock engaged: ignore switching commands
// [R11] handle low (manual): ignore switching commands
// [R12] switch only with padlock free, handle, emergency high
// [R13] 0xac00 switches off, 0xac01 switches on
// [R14] host rereads state about one second later
// [R15] timeout in tenths drops output; zero disables
// [R16] refused command changes nothing, never queued
`ifndef MSI_REGS_SVH
`define MSI_REGS_SVH

// ************************************************************
// register offsets (protocol addresses minus base)
// ************************************************************
`define MSI_IN_STATE      16'h0000
`define MSI_IN_INLK       16'h0001
`define MSI_HOLD_CMD      16'h0000
`define MSI_HOLD_TMO      16'h0001
`define MSI_REG_COUNT     16'h0002
`define MSI_TMO_RESET     16'h0000

// ************************************************************
// command values, function codes, exception codes
// ************************************************************
`define MSI_CMD_OFF       16'hac00
`define MSI_CMD_ON        16'hac01
`define MSI_FC_RD_HOLD    8'h03
`define MSI_FC_RD_INPUT   8'h04
`define MSI_FC_WR_SINGLE  8'h06
`define MSI_FC_EXC_FLAG   8'h80
`define MSI_EXC_FUNC      8'h01
`define MSI_EXC_ADDR      8'h02
`define MSI_EXC_VALUE     8'h03
`define MSI_NODE_BCAST    5'h00
`define MSI_PROTO_MODBUS  2'h0
`define MSI_REQ_LEN       4'h8
`define MSI_CRC_INIT      16'hffff
`define MSI_CRC_POLY      16'ha001

// ************************************************************
// field positions of the interlock inputs word
// ************************************************************
`define MSI_BIT_PADLOCK   0
`define MSI_BIT_HANDLE    1
`define MSI_BIT_EMERG     2

// ************************************************************
// timing
// ************************************************************
`define MSI_CLK_HZ        100000000
`define MSI_BAUD_LO       19200
`define MSI_BAUD_HI       38400
`define MSI_GAP_BITS      39
`define MSI_TICK_MS       100
`define MSI_LED_HALF_MS   1000
`define MSI_LED_HALF_TICKS (`MSI_LED_HALF_MS / `MSI_TICK_MS)
`define MSI_ACT_HOLD_TICKS 5

`endif

// ### inc/msi_pkg.sv
// types of the motor switch interlock controller
package msi_pkg;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic emergency;
    logic handle;
    logic padlock;
  } msi_inlk_t;

  typedef struct packed {
    logic [4:0] node;
    logic       baud_hi;
    logic [1:0] proto;
  } msi_dip_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } msi_byte_t;

  // ************************************************************
  // frame engine states
  // ************************************************************
  typedef enum logic [1:0] {
    MSI_ST_RECV = 2'b00,
    MSI_ST_EXEC = 2'b01,
    MSI_ST_SEND = 2'b10
  } msi_state_t;

endpackage : msi_pkg

// ### verilog/msi_uart.sv
// serial byte receiver and transmitter, 8 data bits, no parity, 1 stop
`timescale 1ns/100ps
`default_nettype none

module msi_uart (
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  input  wire logic [15:0]      bit_cyc,
  input  wire logic             rxd,
  output msi_pkg::msi_byte_t    rx_byte,
  input  wire logic             tx_valid,
  input  wire logic [7:0]       tx_data,
  output logic                  tx_ready,
  output logic                  txd
);

  logic        rx_busy_r, rx_busy_nxt;
  logic [15:0] rx_cnt_r,  rx_cnt_nxt;
  logic [3:0]  rx_bit_r,  rx_bit_nxt;
  logic [7:0]  rx_sh_r,   rx_sh_nxt;
  msi_pkg::msi_byte_t rx_out_r, rx_out_nxt;
  logic        tx_busy_r, tx_busy_nxt;
  logic [15:0] tx_cnt_r,  tx_cnt_nxt;
  logic [3:0]  tx_bit_r,  tx_bit_nxt;
  logic [9:0]  tx_sh_r,   tx_sh_nxt;
  logic        txd_r,     txd_nxt;

  // receiver: sample mid-bit, start, 8 data lsb first, stop
  always_comb begin
    rx_busy_nxt = rx_busy_r;
    rx_cnt_nxt  = rx_cnt_r;
    rx_bit_nxt  = rx_bit_r;
    rx_sh_nxt   = rx_sh_r;
    rx_out_nxt  = '0;
    if (!rx_busy_r) begin
      if (!rxd) begin
        rx_busy_nxt = 1'b1;
        rx_cnt_nxt  = bit_cyc >> 1;
        rx_bit_nxt  = 4'h0;
      end
    end else if (rx_cnt_r != 16'h0000) begin
      rx_cnt_nxt = rx_cnt_r - 16'h0001;
    end else begin
      rx_cnt_nxt = bit_cyc - 16'h0001;
      rx_bit_nxt = rx_bit_r + 4'h1;
      if (rx_bit_r == 4'h0) begin
        rx_busy_nxt = ~rxd;                          // false start
      end else if (rx_bit_r < 4'h9) begin
        rx_sh_nxt = {rxd, rx_sh_r[7:1]};
      end else begin
        rx_busy_nxt      = 1'b0;
        rx_out_nxt.valid = rxd;                      // bad stop bit drops byte
        rx_out_nxt.data  = rx_sh_r;
      end
    end
  end

  // transmitter: shift a 10 bit frame out
  always_comb begin
    tx_busy_nxt = tx_busy_r;
    tx_cnt_nxt  = tx_cnt_r;
    tx_bit_nxt  = tx_bit_r;
    tx_sh_nxt   = tx_sh_r;
    txd_nxt     = txd_r;
    if (!tx_busy_r) begin
      txd_nxt = 1'b1;
      if (tx_valid) begin
        tx_busy_nxt = 1'b1;
        tx_sh_nxt   = {1'b1, tx_data, 1'b0};
        tx_cnt_nxt  = 16'h0000;
        tx_bit_nxt  = 4'h0;
      end
    end else if (tx_cnt_r != 16'h0000) begin
      tx_cnt_nxt = tx_cnt_r - 16'h0001;
    end else if (tx_bit_r == 4'ha) begin
      tx_busy_nxt = 1'b0;
    end else begin
      txd_nxt    = tx_sh_r[0];
      tx_sh_nxt  = {1'b1, tx_sh_r[9:1]};
      tx_bit_nxt = tx_bit_r + 4'h1;
      tx_cnt_nxt = bit_cyc - 16'h0001;
    end
  end

  // state registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rx_busy_r <= 1'b0;
      rx_cnt_r  <= 16'h0000;
      rx_bit_r  <= 4'h0;
      rx_sh_r   <= 8'h00;
      rx_out_r  <= '0;
      tx_busy_r <= 1'b0;
      tx_cnt_r  <= 16'h0000;
      tx_bit_r  <= 4'h0;
      tx_sh_r   <= 10'h3ff;
      txd_r     <= 1'b1;
    end else begin
      rx_busy_r <= rx_busy_nxt;
      rx_cnt_r  <= rx_cnt_nxt;
      rx_bit_r  <= rx_bit_nxt;
      rx_sh_r   <= rx_sh_nxt;
      rx_out_r  <= rx_out_nxt;
      tx_busy_r <= tx_busy_nxt;
      tx_cnt_r  <= tx_cnt_nxt;
      tx_bit_r  <= tx_bit_nxt;
      tx_sh_r   <= tx_sh_nxt;
      txd_r     <= txd_nxt;
    end
  end

  assign rx_byte  = rx_out_r;
  assign tx_ready = ~tx_busy_r;
  assign txd      = txd_r;

endmodule : msi_uart
`default_nettype wire

// ### verilog/msi_top.sv
// motor switch interlock controller with serial register access
`timescale 1ns/100ps
`default_nettype none
`include "msi_regs.svh"

module msi_top #(
  parameter int BIT_CYC_LO = `MSI_CLK_HZ / `MSI_BAUD_LO,
  parameter int BIT_CYC_HI = `MSI_CLK_HZ / `MSI_BAUD_HI,
  parameter int TICK_CYC   = `MSI_CLK_HZ / 1000 * `MSI_TICK_MS
) (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       rs485_rx,
  output logic            rs485_tx,
  output logic            rs485_tx_oe,
  input  wire logic [7:0] dip_sw,
  input  wire logic       padlock_lock_input,
  input  wire logic       handle_presence_input,
  input  wire logic       emergency_button_input,
  output logic            switch_on,
  output logic            led_a,
  output logic            led_b
);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [15:0] msi_crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] x;
    x = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ `MSI_CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction : msi_crc_byte

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [11:0] sync1_r, sync2_r;
  msi_pkg::msi_inlk_t inlk;
  msi_pkg::msi_dip_t  dip;
  logic               rxd_s;

  // two flops on every pin input
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= 12'h001;
      sync2_r <= 12'h001;
    end else begin
      sync1_r <= {dip_sw, emergency_button_input, handle_presence_input,
                  padlock_lock_input, rs485_rx};
      sync2_r <= sync1_r;
    end
  end

  assign rxd_s = sync2_r[0];
  assign inlk  = sync2_r[3:1];                              // [R9]
  assign dip   = sync2_r[11:4];                             // [R6]

  // ************************************************************
  // timebase and indicator leds
  // ************************************************************
  logic [31:0] tick_cnt_r, tick_cnt_nxt;
  logic [7:0]  slow_cnt_r, slow_cnt_nxt;
  logic [7:0]  act_cnt_r,  act_cnt_nxt;
  logic        slow_ph_r,  slow_ph_nxt;
  logic        fast_ph_r,  fast_ph_nxt;
  logic        led_a_r,    led_a_nxt;
  logic        led_b_r,    led_b_nxt;
  logic        tick;
  logic        frame_hit;

  assign tick = (tick_cnt_r == 32'(TICK_CYC - 1));

  // tenth-second tick, one second half period, activity hold
  always_comb begin
    tick_cnt_nxt = tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
    slow_cnt_nxt = slow_cnt_r;
    slow_ph_nxt  = slow_ph_r;
    fast_ph_nxt  = fast_ph_r;
    act_cnt_nxt  = act_cnt_r;
    if (tick) begin
      fast_ph_nxt = ~fast_ph_r;
      if (act_cnt_r != 8'h00) act_cnt_nxt = act_cnt_r - 8'h01;
      if (slow_cnt_r == 8'(`MSI_LED_HALF_TICKS - 1)) begin
        slow_cnt_nxt = 8'h00;
        slow_ph_nxt  = ~slow_ph_r;
      end else begin
        slow_cnt_nxt = slow_cnt_r + 8'h01;
      end
    end
    if (frame_hit) act_cnt_nxt = 8'(`MSI_ACT_HOLD_TICKS);
    if (act_cnt_r != 8'h00) begin
      led_a_nxt = fast_ph_r;                                // [R1]
      led_b_nxt = fast_ph_r;                                // [R1]
    end else if (!inlk.emergency) begin
      led_a_nxt = slow_ph_r;                                // [R2]
      led_b_nxt = slow_ph_r;                                // [R2]
    end else begin
      led_a_nxt = slow_ph_r;                                // [R3]
      led_b_nxt = ~slow_ph_r;                               // [R3]
    end
  end

  // led registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_r <= 32'h0000_0000;
      slow_cnt_r <= 8'h00;
      act_cnt_r  <= 8'h00;
      slow_ph_r  <= 1'b0;
      fast_ph_r  <= 1'b0;
      led_a_r    <= 1'b0;
      led_b_r    <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      slow_cnt_r <= slow_cnt_nxt;
      act_cnt_r  <= act_cnt_nxt;
      slow_ph_r  <= slow_ph_nxt;
      fast_ph_r  <= fast_ph_nxt;
      led_a_r    <= led_a_nxt;
      led_b_r    <= led_b_nxt;
    end
  end

  // ************************************************************
  // serial port
  // ************************************************************
  logic [15:0]        bit_cyc;
  msi_pkg::msi_byte_t rx_byte;
  logic               tx_valid, tx_ready;
  logic [7:0]         tx_data;

  assign bit_cyc = dip.baud_hi ? 16'(BIT_CYC_HI) : 16'(BIT_CYC_LO);  // [R4] [R5]

  msi_uart u_uart (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .bit_cyc  (bit_cyc),
    .rxd      (rxd_s),
    .rx_byte  (rx_byte),
    .tx_valid (tx_valid),
    .tx_data  (tx_data),
    .tx_ready (tx_ready),
    .txd      (rs485_tx)
  );

  // ************************************************************
  // frame engine
  // ************************************************************
  msi_pkg::msi_state_t st_r, st_nxt;
  logic [7:0]  rx_buf_r [0:7];
  logic [7:0]  rx_buf_nxt [0:7];
  logic [7:0]  tx_buf_r [0:6];
  logic [7:0]  tx_buf_nxt [0:6];
  logic [3:0]  rx_idx_r, rx_idx_nxt;
  logic [3:0]  tx_idx_r, tx_idx_nxt;
  logic [3:0]  tx_len_r, tx_len_nxt;
  logic [15:0] rx_crc_r, rx_crc_nxt;
  logic [15:0] tx_crc_r, tx_crc_nxt;
  logic [31:0] gap_r,    gap_nxt;
  logic        in_fr_r,  in_fr_nxt;
  logic        oe_r,     oe_nxt;
  logic [7:0]  fc;
  logic [15:0] ra, val, rd0, rd1;
  logic [31:0] gap_cyc;
  logic        frame_ok, wr_cmd, wr_tmo;
  logic        sw_on_r, sw_on_nxt;
  logic [15:0] tmo_r,   tmo_nxt;
  logic [15:0] tcnt_r,  tcnt_nxt;

  // request fields and register reads
  assign fc      = rx_buf_r[1];
  assign ra      = {rx_buf_r[2], rx_buf_r[3]};
  assign val     = {rx_buf_r[4], rx_buf_r[5]};
  assign gap_cyc = {16'h0000, bit_cyc} * 32'(`MSI_GAP_BITS);
  assign frame_ok = (rx_idx_r == `MSI_REQ_LEN) && (rx_crc_r == 16'h0000)
                  && (dip.proto == `MSI_PROTO_MODBUS)
                  && (rx_buf_r[0] == {3'h0, dip.node} || rx_buf_r[0][4:0] == `MSI_NODE_BCAST
                      && rx_buf_r[0][7:5] == 3'h0);
  assign frame_hit = (st_r == msi_pkg::MSI_ST_EXEC);
  // input words: switch state and interlocks; holding: command reads zero
  assign rd0 = (fc == `MSI_FC_RD_INPUT) ? {15'h0000, sw_on_r} : 16'h0000;  // [R7] [R8]
  assign rd1 = (fc == `MSI_FC_RD_INPUT) ? {13'h0000, inlk} : tmo_r;        // [R9] [R15]
  assign wr_cmd = frame_hit && fc == `MSI_FC_WR_SINGLE && ra == `MSI_HOLD_CMD
               && (val == `MSI_CMD_ON || val == `MSI_CMD_OFF);             // [R13]
  assign wr_tmo = frame_hit && fc == `MSI_FC_WR_SINGLE && ra == `MSI_HOLD_TMO;

  // receive, decode, answer
  always_comb begin
    st_nxt     = st_r;
    rx_buf_nxt = rx_buf_r;
    tx_buf_nxt = tx_buf_r;
    rx_idx_nxt = rx_idx_r;
    tx_idx_nxt = tx_idx_r;
    tx_len_nxt = tx_len_r;
    rx_crc_nxt = rx_crc_r;
    tx_crc_nxt = tx_crc_r;
    gap_nxt    = gap_r;
    in_fr_nxt  = in_fr_r;
    tx_valid   = 1'b0;
    tx_data    = 8'h00;
    case (st_r)
      msi_pkg::MSI_ST_RECV: begin
        if (rx_byte.valid) begin
          in_fr_nxt = 1'b1;
          gap_nxt   = 32'h0000_0000;
          if (rx_idx_r < `MSI_REQ_LEN) begin
            rx_buf_nxt[rx_idx_r[2:0]] = rx_byte.data;
            rx_crc_nxt = msi_crc_byte(rx_crc_r, rx_byte.data);
          end
          if (rx_idx_r <= `MSI_REQ_LEN) rx_idx_nxt = rx_idx_r + 4'h1;
        end else if (in_fr_r) begin
          gap_nxt = gap_r + 32'h0000_0001;
          if (gap_r >= gap_cyc) begin
            in_fr_nxt  = 1'b0;
            rx_idx_nxt = 4'h0;
            rx_crc_nxt = `MSI_CRC_INIT;
            if (frame_ok) st_nxt = msi_pkg::MSI_ST_EXEC;
          end
        end
      end
      msi_pkg::MSI_ST_EXEC: begin
        tx_buf_nxt[0] = rx_buf_r[0];
        tx_buf_nxt[1] = fc;
        tx_idx_nxt    = 4'h0;
        tx_crc_nxt    = `MSI_CRC_INIT;
        st_nxt        = (rx_buf_r[0] == 8'h00) ? msi_pkg::MSI_ST_RECV : msi_pkg::MSI_ST_SEND;
        if (fc == `MSI_FC_RD_HOLD || fc == `MSI_FC_RD_INPUT) begin
          if (val == 16'h0000 || val > `MSI_REG_COUNT || ra >= `MSI_REG_COUNT
              || ra + val > `MSI_REG_COUNT) begin
            tx_buf_nxt[1] = fc | `MSI_FC_EXC_FLAG;
            tx_buf_nxt[2] = `MSI_EXC_ADDR;
            tx_len_nxt    = 4'h3;
          end else begin
            tx_buf_nxt[2] = {val[6:0], 1'b0};
            tx_buf_nxt[3] = (ra == 16'h0000) ? rd0[15:8] : rd1[15:8];
            tx_buf_nxt[4] = (ra == 16'h0000) ? rd0[7:0]  : rd1[7:0];
            tx_buf_nxt[5] = rd1[15:8];
            tx_buf_nxt[6] = rd1[7:0];
            tx_len_nxt    = 4'h3 + {val[2:0], 1'b0};
          end
        end else if (fc == `MSI_FC_WR_SINGLE) begin
          tx_buf_nxt[2] = rx_buf_r[2];
          tx_buf_nxt[3] = rx_buf_r[3];
          tx_buf_nxt[4] = rx_buf_r[4];
          tx_buf_nxt[5] = rx_buf_r[5];
          tx_len_nxt    = 4'h6;
          if (!wr_cmd && !wr_tmo) begin
            tx_buf_nxt[1] = fc | `MSI_FC_EXC_FLAG;
            tx_buf_nxt[2] = (ra == `MSI_HOLD_CMD) ? `MSI_EXC_VALUE : `MSI_EXC_ADDR;
            tx_len_nxt    = 4'h3;
          end
        end else begin
          tx_buf_nxt[1] = fc | `MSI_FC_EXC_FLAG;
          tx_buf_nxt[2] = `MSI_EXC_FUNC;
          tx_len_nxt    = 4'h3;
        end
      end
      msi_pkg::MSI_ST_SEND: begin
        if (tx_idx_r < tx_len_r + 4'h2) begin
          tx_valid = 1'b1;
          if (tx_idx_r < tx_len_r) tx_data = tx_buf_r[tx_idx_r[2:0]];
          else if (tx_idx_r == tx_len_r) tx_data = tx_crc_r[7:0];
          else tx_data = tx_crc_r[15:8];
          if (tx_ready) begin
            tx_idx_nxt = tx_idx_r + 4'h1;
            if (tx_idx_r < tx_len_r) tx_crc_nxt = msi_crc_byte(tx_crc_r, tx_data);
          end
        end else if (tx_ready) begin
          st_nxt = msi_pkg::MSI_ST_RECV;
        end
      end
      default: st_nxt = msi_pkg::MSI_ST_RECV;
    endcase
    oe_nxt = (st_nxt == msi_pkg::MSI_ST_SEND);
  end

  // frame engine registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_r     <= msi_pkg::MSI_ST_RECV;
      rx_buf_r <= '{default: 8'h00};
      tx_buf_r <= '{default: 8'h00};
      rx_idx_r <= 4'h0;
      tx_idx_r <= 4'h0;
      tx_len_r <= 4'h0;
      rx_crc_r <= `MSI_CRC_INIT;
      tx_crc_r <= `MSI_CRC_INIT;
      gap_r    <= 32'h0000_0000;
      in_fr_r  <= 1'b0;
      oe_r     <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      rx_buf_r <= rx_buf_nxt;
      tx_buf_r <= tx_buf_nxt;
      rx_idx_r <= rx_idx_nxt;
      tx_idx_r <= tx_idx_nxt;
      tx_len_r <= tx_len_nxt;
      rx_crc_r <= rx_crc_nxt;
      tx_crc_r <= tx_crc_nxt;
      gap_r    <= gap_nxt;
      in_fr_r  <= in_fr_nxt;
      oe_r     <= oe_nxt;
    end
  end

  // ************************************************************
  // switch control and communication timeout
  // ************************************************************
  always_comb begin
    sw_on_nxt = sw_on_r;
    tmo_nxt   = tmo_r;
    tcnt_nxt  = tcnt_r;
    if (tick && sw_on_r && tmo_r != 16'h0000) begin
      tcnt_nxt = tcnt_r + 16'h0001;
      if (tcnt_r + 16'h0001 >= tmo_r) sw_on_nxt = 1'b0;     // [R15]
    end
    // refused commands fall through untouched and are dropped
    if (wr_cmd && !inlk.padlock && inlk.handle && inlk.emergency) begin  // [R10] [R11] [R12] [R16]
      sw_on_nxt = (val == `MSI_CMD_ON);                     // [R13]
      tcnt_nxt  = 16'h0000;
    end
    if (wr_tmo) tmo_nxt = val;
    if (!inlk.emergency) sw_on_nxt = 1'b0;                  // [R2]
  end

  // switch registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sw_on_r <= 1'b0;
      tmo_r   <= `MSI_TMO_RESET;
      tcnt_r  <= 16'h0000;
    end else begin
      sw_on_r <= sw_on_nxt;
      tmo_r   <= tmo_nxt;
      tcnt_r  <= tcnt_nxt;
    end
  end

  assign switch_on   = sw_on_r;
  assign rs485_tx_oe = oe_r;
  assign led_a       = led_a_r;
  assign led_b       = led_b_r;

endmodule : msi_top
`default_nettype wire

// ### verif/msi_top_assertions.sv
// assertions on the interlock controller pins
`timescale 1ns/100ps
`default_nettype none

module msi_chk (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic rs485_tx,
  input wire logic rs485_tx_oe,
  input wire logic padlock_lock_input,
  input wire logic handle_presence_input,
  input wire logic emergency_button_input,
  input wire logic switch_on,
  input wire logic led_a,
  input wire logic led_b
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // switch drive and leds
  a_emerg_off: assert property ((!emergency_button_input)[*4] |-> !switch_on)
    else $error("on in emergency");
  a_emerg_leds: assert property ((!emergency_button_input)[*4] |-> led_a == led_b)
    else $error("leds apart");
  a_on_cause: assert property ($rose(switch_on) |-> !$past(padlock_lock_input, 3)
    && $past(handle_presence_input, 3) && $past(emergency_button_input, 3))
    else $error("on while interlocked");
  a_on_reply: assert property ($rose(switch_on) |-> ##[0:4] rs485_tx_oe)
    else $error("on without answer");
  // serial answer framing
  a_tx_idle: assert property (!rs485_tx_oe |-> rs485_tx)
    else $error("line not idle");
  a_oe_start: assert property ($rose(rs485_tx_oe) |-> ##[1:2] !rs485_tx)
    else $error("no start bit");
  a_oe_hold: assert property ($rose(rs485_tx_oe) |-> rs485_tx_oe[*8])
    else $error("enable too short");
  a_oe_stop: assert property ($fell(rs485_tx_oe) |-> $past(rs485_tx) && rs485_tx)
    else $error("released in a byte");
  c_on: cover property ($rose(switch_on));
  c_off: cover property ($fell(switch_on));
  c_reply: cover property ($rose(rs485_tx_oe));
endmodule : msi_chk

bind msi_top msi_chk i_msi_chk (
  .clk_sys(clk_sys), .nrst(nrst), .rs485_tx(rs485_tx), .rs485_tx_oe(rs485_tx_oe),
  .padlock_lock_input(padlock_lock_input), .handle_presence_input(handle_presence_input),
  .emergency_button_input(emergency_button_input), .switch_on(switch_on),
  .led_a(led_a), .led_b(led_b)
);

`default_nettype wire

// ### verif/msi_host_model.sv
// serial host: sends requests, collects answers
`timescale 1ns/100ps
`default_nettype none

module msi_host_model #(
  parameter int BIT_CYC = 8
) (
  input  wire logic clk_sys,
  output logic      line_out,
  input  wire logic line_in,
  input  wire logic line_oe
);
  logic [7:0] rsp [$];
  initial line_out = 1'b1;
  // transmit: start, 8 data lsb first, stop
  task automatic put_byte(input logic [7:0] b);
    for (int i = 0; i < 10; i++) begin
      line_out = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
      repeat (BIT_CYC) @(negedge clk_sys);
    end
  endtask : put_byte

  // frame with crc, low crc byte first
  task automatic request(input logic [7:0] node, input logic [7:0] fc,
                         input logic [15:0] adr, input logic [15:0] val);
    logic [7:0]  f [8];
    logic [15:0] crc;
    f = '{node, fc, adr[15:8], adr[7:0], val[15:8], val[7:0], 8'h00, 8'h00};
    crc = 16'hffff;
    for (int i = 0; i < 6; i++) begin
      crc ^= {8'h00, f[i]};
      for (int k = 0; k < 8; k++) crc = crc[0] ? (crc >> 1) ^ 16'ha001 : crc >> 1;
    end
    f[6] = crc[7:0];
    f[7] = crc[15:8];
    rsp.delete();
    for (int i = 0; i < 8; i++) put_byte(f[i]);
  endtask : request

  // receive: sample mid-cell while the device drives
  initial begin : rx_loop
    logic [7:0] b;
    forever begin
      @(negedge line_in iff line_oe);
      repeat (BIT_CYC / 2) @(posedge clk_sys);
      for (int k = 0; k < 8; k++) begin
        repeat (BIT_CYC) @(posedge clk_sys);
        b[k] = line_in;
      end
      rsp.push_back(b);
      repeat (BIT_CYC) @(posedge clk_sys);
    end
  end
endmodule : msi_host_model

`default_nettype wire

// ### verif/motor_switch_interlock_tb_top.sv
// bench of the interlock controller
`timescale 1ns/100ps
`default_nettype none
`include "msi_regs.svh"

module motor_switch_interlock_tb_top;
  typedef struct packed {
    msi_pkg::msi_inlk_t inlk;
    logic [15:0]        cmd;
    logic               exp_on;
  } msi_row_t;
  logic       clk_sys = 1'b0;
  logic       nrst = 1'b0;
  logic [7:0] dip_sw = 8'h2c;
  logic       padlock_lock_input = 1'b0;
  logic       handle_presence_input = 1'b1;
  logic       emergency_button_input = 1'b1;
  logic       a0;
  wire logic  rs485_rx, rs485_tx, rs485_tx_oe, switch_on, led_a, led_b;
  int         err_count = 0;
  int         n_compared = 0;
  msi_row_t   rows [7] = '{'{3'h6, `MSI_CMD_ON, 1'b1}, '{3'h6, `MSI_CMD_OFF, 1'b0},
    '{3'h6, `MSI_CMD_ON, 1'b1}, '{3'h7, `MSI_CMD_OFF, 1'b1}, '{3'h4, `MSI_CMD_OFF, 1'b1},
    '{3'h6, `MSI_CMD_OFF, 1'b0}, '{3'h2, `MSI_CMD_ON, 1'b0}};

  always #5 clk_sys = ~clk_sys;

  msi_top #(.BIT_CYC_LO(16), .BIT_CYC_HI(8), .TICK_CYC(100)) i_msi_top (
    .clk_sys(clk_sys), .nrst(nrst), .rs485_rx(rs485_rx), .rs485_tx(rs485_tx),
    .rs485_tx_oe(rs485_tx_oe), .dip_sw(dip_sw), .padlock_lock_input(padlock_lock_input),
    .handle_presence_input(handle_presence_input),
    .emergency_button_input(emergency_button_input), .switch_on(switch_on),
    .led_a(led_a), .led_b(led_b));
  msi_host_model #(.BIT_CYC(8)) i_msi_host_model (
    .clk_sys(clk_sys), .line_out(rs485_rx), .line_in(rs485_tx), .line_oe(rs485_tx_oe));

  // helpers
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  function automatic logic [7:0] rb(input int k);
    return i_msi_host_model.rsp[k];
  endfunction : rb

  // request, then wait out the answer
  task automatic xfer(input logic [7:0] fc, input logic [15:0] adr, input logic [15:0] val);
    int n, m;
    i_msi_host_model.request(8'h05, fc, adr, val);
    for (n = 0; n < 2000 && rs485_tx_oe !== 1'b1; n++) @(negedge clk_sys);
    for (m = n; m < 2000 && rs485_tx_oe !== 1'b0; m++) @(negedge clk_sys);
    check(m < 2000, 1'b1, "answer in time");
    repeat (4) @(negedge clk_sys);
  endtask : xfer

  task automatic exc(input logic [7:0] fc, input logic [15:0] adr, input logic [15:0] val,
                     input logic [7:0] code);
    xfer(fc, adr, val);
    check({rb(1), rb(2)}, {fc | 8'h80, code}, "exception reply");
  endtask : exc

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  // main sequence
  initial begin
    repeat (2) @(negedge clk_sys);
    check({rs485_tx, rs485_tx_oe, switch_on, led_a, led_b}, 16'h0010, "reset pins");
    nrst = 1'b1;
    repeat (5) @(negedge clk_sys);
    $display("test reset done");
    foreach (rows[i]) begin
      {emergency_button_input, handle_presence_input, padlock_lock_input} = rows[i].inlk;
      repeat (5) @(negedge clk_sys);
      xfer(8'h06, `MSI_HOLD_CMD, rows[i].cmd);
      check({rb(4), rb(5)}, rows[i].cmd, "echo data");
      check(switch_on, rows[i].exp_on, "switch drive");
      xfer(8'h04, `MSI_IN_STATE, 16'h0002);
      check(rb(2), 16'h0004, "byte count");
      check(rb(4), rows[i].exp_on, "state word");
      check(rb(6), rows[i].inlk, "inputs word");
      $display("test row %0d done", i);
    end
    // emergency drops the switch, no replay
    {emergency_button_input, handle_presence_input, padlock_lock_input} = 3'h6;
    repeat (5) @(negedge clk_sys);
    xfer(8'h06, `MSI_HOLD_CMD, `MSI_CMD_ON);
    check(switch_on, 1'b1, "switch on");
    emergency_button_input = 1'b0;
    repeat (6) @(negedge clk_sys);
    check(switch_on, 1'b0, "emergency off");
    check(led_a ^ led_b, 1'b0, "leds together");
    emergency_button_input = 1'b1;
    repeat (600) @(negedge clk_sys);
    check(switch_on, 1'b0, "no replay");
    check(led_a ^ led_b, 1'b1, "leds alternate");
    $display("test emergency done");
    // one second comm loss timeout, then none
    xfer(8'h06, `MSI_HOLD_TMO, 16'h000a);
    xfer(8'h06, `MSI_HOLD_CMD, `MSI_CMD_ON);
    check(switch_on, 1'b1, "before timeout");
    repeat (500) @(negedge clk_sys);
    check(switch_on, 1'b0, "after timeout");
    xfer(8'h06, `MSI_HOLD_TMO, 16'h0000);
    xfer(8'h06, `MSI_HOLD_CMD, `MSI_CMD_ON);
    repeat (1500) @(negedge clk_sys);
    check(switch_on, 1'b1, "timeout disabled");
    $display("test timeout done");
    // activity flashing after a frame, then exception replies
    i_msi_host_model.request(8'h05, 8'h04, `MSI_IN_STATE, 16'h0001);
    repeat (350) @(negedge clk_sys);
    check(led_a ^ led_b, 1'b0, "activity in phase");
    a0 = led_a;
    repeat (100) @(negedge clk_sys);
    check(led_a ^ a0, 1'b1, "activity toggles");
    repeat (1000) @(negedge clk_sys);
    exc(8'h05, `MSI_HOLD_CMD, 16'h0000, 8'h01);
    exc(8'h06, `MSI_HOLD_CMD, 16'h1234, 8'h03);
    exc(8'h04, 16'h0002, 16'h0001, 8'h02);
    // other protocols are ignored
    dip_sw = 8'h2d;
    repeat (5) @(negedge clk_sys);
    i_msi_host_model.request(8'h05, 8'h04, `MSI_IN_STATE, 16'h0001);
    repeat (500) @(negedge clk_sys);
    check(16'(i_msi_host_model.rsp.size()), 16'h0000, "protocol ignored");
    $display("test protocol done");
    report_and_stop();
  end

  // watchdog over the whole run
  initial begin
    repeat (100000) @(posedge clk_sys);
    check(1'b0, 1'b1, "watchdog expired");
    report_and_stop();
  end
endmodule : motor_switch_interlock_tb_top

`default_nettype wire
